// ### dv/sdl_host_model.sv
`timescale 1ns/1ps
module sdl_host_model
   import sdl_pkg::*;
(
   output logic sck, // link clock, still outside frames
   output logic cs_n, // chip select, active low
   output sdl_req_t req, // read kind and address-done
   input wire sdl_stat_t stat // link status
);
   logic osc = 1'b0;
   logic run = 1'b0;
   always #80 osc = ~osc;
   assign sck = osc & run;
   initial begin
      cs_n = 1'b1;
      req = '0;
   end
   // codes 00b-10b select rows where slow read is refused; the code 11b row takes every kind
   task frame(input sdl_kind_t k, output int n);
      @(negedge osc);
      cs_n <= 1'b0;
      run <= 1'b1;
      req.kind <= k;
      repeat (2) @(posedge sck);
      req.addr_done <= 1'b1;
      @(posedge sck);
      req.addr_done <= 1'b0;
      n = 0;
      do begin
         @(negedge osc);
         n++;
      end while (!stat.drive && !stat.unsup && n < 20);
      if (stat.unsup) n = 0;
   endtask : frame
   task stop;
      @(negedge osc);
      run <= 1'b0;
      cs_n <= 1'b1;
      req.kind <= sdl_kind_t'(~req.kind);
   endtask : stop
endmodule : sdl_host_model

// ### dv/sdl_latency_sva.sv
`timescale 1ns/1ps
module sdl_latency_sva
   import sdl_pkg::*;
#(parameter int CW = 5) (
   input wire logic clk_sys, // clock
   input wire logic rstn, // reset
   input wire logic ce, // enable
   input wire logic [1:0] latency_code, // code
   input wire logic [6:0] qry_addr, // offset
   input wire logic qry_rd, // strobe
   input wire logic [7:0] qry_data, // byte
   input wire logic qry_valid, // valid
   input wire logic drive_sys, // drive
   input wire logic sck, // link clock
   input wire logic cs_n, // select
   input wire sdl_req_t req, // request
   input wire sdl_stat_t stat // status
);
   a_qry_answer: assert property (@(posedge clk_sys) disable iff (!rstn)
      qry_rd && ce |=> qry_valid) else $error("no answer");
   a_row90_freq: assert property (@(posedge clk_sys) disable iff (!rstn)
      qry_rd && ce && qry_addr == 7'h2E |=> qry_data == 8'h5A) else $error("row 90");
   a_row104_code: assert property (@(posedge clk_sys) disable iff (!rstn)
      qry_rd && ce && qry_addr == 7'h3D |=> qry_data == 8'h02) else $error("row 104");
   a_row133_freq: assert property (@(posedge clk_sys) disable iff (!rstn)
      qry_rd && ce && qry_addr == 7'h4A |=> qry_data == 8'h85) else $error("row 133");
   a_qio133_void: assert property (@(posedge clk_sys) disable iff (!rstn)
      qry_rd && ce && qry_addr == 7'h56 |=> qry_data == 8'hFF) else $error("qio 133");
   a_unsup_silent: assert property (@(posedge sck) disable iff (!rstn)
      stat.unsup |-> !stat.drive) else $error("unsup drives");
   a_slow_refused: assert property (@(posedge sck) disable iff (!rstn)
      req.addr_done && !cs_n && req.kind == SDL_K_SLOW && latency_code != 2'h3
      && stat == '0 |=> stat.unsup) else $error("slow accepted");
   a_qio_count: assert property (@(posedge sck) disable iff (!rstn)
      req.addr_done && !cs_n && req.kind == SDL_K_QIO && latency_code == 2'h1
      && stat == '0 |=> stat.cycles == 5'h06) else $error("qio count");
endmodule : sdl_latency_sva

// ### dv/sdl_latency_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t %s", $time, m); end end
bind sdl_latency sdl_latency_sva #(.CW(CW)) sdl_latency_sva_i (.clk_sys, .rstn, .ce,
   .latency_code, .qry_addr, .qry_rd, .qry_data, .qry_valid, .drive_sys, .sck, .cs_n,
   .req, .stat);
module sdl_latency_tb_top
   import sdl_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic [1:0] latency_code = 2'h0;
   logic [6:0] qry_addr = 7'h00;
   logic qry_rd = 1'b0;
   logic [7:0] qry_data;
   logic qry_valid;
   logic drive_sys;
   logic sck;
   logic cs_n;
   sdl_req_t req;
   sdl_stat_t stat;
   int fails = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #5 clk_sys = ~clk_sys;
   sdl_latency #(.CW(5)) sdl_latency_i (.clk_sys, .rstn, .ce, .latency_code, .qry_addr,
      .qry_rd, .qry_data, .qry_valid, .drive_sys, .sck, .cs_n, .req, .stat);
   sdl_host_model sdl_host_model_i (.sck, .cs_n, .req, .stat);
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         close_out;
      end
   end
   task close_out;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   // back-to-back query reads, offset in the high byte
   task t_query;
      logic [15:0] qv [0:15] = '{16'h2E5A, 16'h2F01, 16'h3C68, 16'h3D02, 16'h4A85, 16'h4B02,
         16'h30FF, 16'h3308, 16'h3901, 16'h4905, 16'h50FF, 16'h56FF, 16'h1303, 16'h2100,
         16'h1F01, 16'h5800};
      for (int i = 0; i <= 16; i++) begin
         @(posedge clk_sys);
         qry_rd <= (i < 16);
         qry_addr <= qv[i % 16][14:8];
         @(negedge clk_sys);
         if (i > 0) `CHK({qry_valid, qry_data}, {1'b1, qv[i - 1][7:0]}, "query")
      end
      $display("t_query done");
   endtask : t_query
   // code, kind, then edges seen until drive (0 when refused)
   task t_reads;
      int n;
      logic [15:0] rv [0:13] = '{16'h0000, 16'h1000, 16'h2000, 16'h3002, 16'h110A, 16'h220A,
         16'h030A, 16'h1407, 16'h2408, 16'h1508, 16'h2509, 16'h3406, 16'h3505, 16'h0406};
      for (int i = 0; i < 14; i++) begin
         @(posedge clk_sys);
         latency_code <= rv[i][13:12];
         repeat (4) @(posedge clk_sys);
         sdl_host_model_i.frame(sdl_kind_t'(rv[i][10:8]), n);
         `CHK(n, int'(rv[i][7:0]), "latency")
         if (n > 0) `CHK(drive_sys, 1'b1, "no drive")
         sdl_host_model_i.stop;
         repeat (6) @(posedge clk_sys);
         @(negedge clk_sys);
         `CHK({drive_sys, stat}, 8'h00, "not cleared")
      end
      $display("t_reads done");
   endtask : t_reads
   // a read strobe taken while the enable is low must leave the port frozen
   task t_freeze;
      @(posedge clk_sys);
      ce <= 1'b0;
      qry_rd <= 1'b1;
      qry_addr <= 7'h2E;
      @(posedge clk_sys);
      qry_rd <= 1'b0;
      @(negedge clk_sys);
      `CHK({qry_valid, qry_data}, 9'h000, "frozen")
      @(posedge clk_sys);
      ce <= 1'b1;
      $display("t_freeze done");
   endtask : t_freeze
   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      t_query;
      t_freeze;
      t_reads;
      close_out;
   end
endmodule : sdl_latency_tb_top

// ### rtl/sdl_latency.sv
`timescale 1ns/1ps
// Overview of operation
// - 90 MHz row: byte 5Ah, code 01b
// - 104 MHz row: byte 68h, code 10b
// - 133 MHz row: byte 85h, code 10b
// - FFh marks unsupported; slow read unsupported above 50
// - fast read: 0 mode, 8 dummy at 80-133
// - dual/quad out: 0 mode, 8 dummy at 80-104
// - dual/quad out unsupported at 133 MHz
// - dual I/O: 4 mode, 0 to 2 dummy
// - quad I/O: 2 mode, 1 dummy at 50, 4 or 5 above
// - dual/quad I/O unsupported at 133 MHz
// - row: freq, code, six mode/latency pairs in order
// - 50 MHz row: code 11b, dual 0, quad 1
// - 80 MHz row: code 00b, slow unsupported, 8 dummy
module sdl_latency
   import sdl_pkg::*;
#(
   parameter int CW = 5
) (
   input wire logic clk_sys, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic ce, // clock enable, freezes clk_sys state and sequencer steps when low; deselect still clears the sequencer
   input wire logic [1:0] latency_code, // programmed latency code
   input wire logic [6:0] qry_addr, // query byte offset in parameter
   input wire logic qry_rd, // query read strobe
   output logic [7:0] qry_data, // query byte
   output logic qry_valid, // query byte valid pulse
   output logic drive_sys, // data drive seen, clk_sys domain
   input wire logic sck, // serial clock from host
   input wire logic cs_n, // chip select, active low
   input sdl_req_t req, // decoded read kind and address-done pulse
   output sdl_stat_t stat // link status in sck domain
);

   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   initial begin
      if (CW < 5 || CW > 8) begin
         $error("sdl_latency: CW must be 5..8");
      end
   end

   // ----------------------------------------
   // table access
   // ----------------------------------------
   function automatic logic [7:0] tbl_byte(input logic [6:0] ofs);
      logic [6:0] idx;
      idx = 7'(ofs - SDL_TBL_FIRST);
      if (ofs < SDL_TBL_FIRST || ofs > SDL_TBL_LAST) begin
         tbl_byte = SDL_RD_VOID;
      end else begin
         tbl_byte = SDL_TBL[idx];
      end
   endfunction : tbl_byte

   function automatic logic [6:0] row_of(input logic [1:0] lc);
      logic [6:0] r;
      r = SDL_ROW_80;
      case (lc)
         SDL_LC_50: r = SDL_ROW_50;
         SDL_LC_80: r = SDL_ROW_80;
         SDL_LC_90: r = SDL_ROW_90;
         SDL_LC_104: r = SDL_ROW_104;
         default: r = SDL_ROW_80;
      endcase
      row_of = r;
   endfunction : row_of

   // ----------------------------------------
   // query read port, clk_sys domain
   // ----------------------------------------
   logic [7:0] qry_data_r;
   logic qry_valid_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         qry_data_r <= 8'h00;
         qry_valid_r <= 1'b0;
      end else if (ce) begin
         qry_valid_r <= qry_rd;
         if (qry_rd) begin
            qry_data_r <= tbl_byte(qry_addr);
         end
      end
   end

   assign qry_data = qry_data_r;
   assign qry_valid = qry_valid_r;

   // ----------------------------------------
   // latency code hold, clk_sys domain
   // ----------------------------------------
   logic [1:0] lc_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lc_r <= SDL_LC_RST;
      end else if (ce) begin
         lc_r <= latency_code;
      end
   end

   // ----------------------------------------
   // crossings into sck domain
   // ----------------------------------------
   // code is quasi-static: host changes it only while deselected
   logic [1:0] lc_s1_r;
   logic [1:0] lc_s2_r;
   logic ce_s1_r;
   logic ce_s2_r;

   always_ff @(posedge sck or negedge rstn) begin
      if (!rstn) begin
         lc_s1_r <= SDL_LC_RST;
         lc_s2_r <= SDL_LC_RST;
         ce_s1_r <= 1'b0;
         ce_s2_r <= 1'b0;
      end else begin
         lc_s1_r <= lc_r;
         lc_s2_r <= lc_s1_r;
         ce_s1_r <= ce;
         ce_s2_r <= ce_s1_r;
      end
   end

   // ----------------------------------------
   // cycle lookup for the requested read
   // ----------------------------------------
   logic [6:0] row_base;
   logic [6:0] col;
   logic [7:0] mode_b;
   logic [7:0] lat_b;
   logic lk_unsup;
   logic [CW-1:0] lk_total;

   always_comb begin
      row_base = row_of(lc_s2_r);
      col = 7'({req.kind, 1'b0});
      mode_b = tbl_byte(7'(row_base + SDL_OFS_MODE + col));
      lat_b = tbl_byte(7'(row_base + SDL_OFS_LAT + col));
      lk_unsup = (mode_b == SDL_UNSUP) || (lat_b == SDL_UNSUP);
      lk_total = CW'(mode_b) + CW'(lat_b);
   end

   // ----------------------------------------
   // read sequencer, sck domain
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_DRIVE,
      ST_HALT
   } sdl_state_t;

   sdl_state_t st_r;
   logic [CW-1:0] cnt_r;
   logic drive_r;
   logic unsup_r;
   logic [4:0] cycles_r;

   // deselect ends the frame even with sck stopped
   always_ff @(posedge sck or negedge rstn or posedge cs_n) begin
      if (!rstn) begin
         st_r <= ST_IDLE;
         cnt_r <= '0;
         drive_r <= 1'b0;
         unsup_r <= 1'b0;
         cycles_r <= 5'h00;
      end else if (cs_n) begin
         st_r <= ST_IDLE;
         cnt_r <= '0;
         drive_r <= 1'b0;
         unsup_r <= 1'b0;
         cycles_r <= 5'h00;
      end else if (ce_s2_r) begin
         case (st_r)
            ST_IDLE: begin
               if (req.addr_done) begin
                  if (lk_unsup) begin
                     st_r <= ST_HALT;
                     unsup_r <= 1'b1;
                  end else begin
                     st_r <= ST_WAIT;
                     cnt_r <= lk_total;
                     cycles_r <= lk_total[4:0];
                  end
               end
            end
            ST_WAIT: begin
               if (cnt_r == '0) begin
                  st_r <= ST_DRIVE;
                  drive_r <= 1'b1;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            ST_DRIVE: begin
               drive_r <= 1'b1;
            end
            ST_HALT: begin
               unsup_r <= 1'b1;
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   assign stat.drive = drive_r;
   assign stat.unsup = unsup_r;
   assign stat.cycles = cycles_r;

   // ----------------------------------------
   // drive level back into clk_sys domain
   // ----------------------------------------
   logic drv_s1_r;
   logic drv_s2_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         drv_s1_r <= 1'b0;
         drv_s2_r <= 1'b0;
      end else if (ce) begin
         drv_s1_r <= drive_r;
         drv_s2_r <= drv_s1_r;
      end
   end

   assign drive_sys = drv_s2_r;

endmodule : sdl_latency

// ### rtl/sdl_pkg.sv
package sdl_pkg;

   // ----------------------------------------
   // query table placement
   // ----------------------------------------
   localparam logic [7:0] SDL_PARAM_ID = 8'h90;
   localparam logic [6:0] SDL_TBL_FIRST = 7'h12;
   localparam logic [6:0] SDL_TBL_LAST = 7'h57;
   localparam logic [6:0] SDL_ROW_LEN = 7'h0E;
   localparam logic [6:0] SDL_ROW_50 = 7'h12;
   localparam logic [6:0] SDL_ROW_80 = 7'h20;
   localparam logic [6:0] SDL_ROW_90 = 7'h2E;
   localparam logic [6:0] SDL_ROW_104 = 7'h3C;
   localparam logic [6:0] SDL_ROW_133 = 7'h4A;
   localparam logic [6:0] SDL_OFS_MODE = 7'h02;
   localparam logic [6:0] SDL_OFS_LAT = 7'h03;
   localparam logic [7:0] SDL_UNSUP = 8'hFF;
   localparam logic [7:0] SDL_RD_VOID = 8'h00;

   // ----------------------------------------
   // latency codes
   // ----------------------------------------
   localparam logic [1:0] SDL_LC_50 = 2'h3;
   localparam logic [1:0] SDL_LC_80 = 2'h0;
   localparam logic [1:0] SDL_LC_90 = 2'h1;
   localparam logic [1:0] SDL_LC_104 = 2'h2;
   localparam logic [1:0] SDL_LC_RST = 2'h0;

   // ----------------------------------------
   // rows 50/80/90/104/133 MHz: freq, code, then mode/latency pairs
   // ----------------------------------------
   localparam logic [7:0] SDL_TBL [0:69] = '{
      8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 8'h01,
      8'h50, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00,
      8'h08, 8'h00, 8'h08, 8'h04, 8'h00, 8'h02, 8'h04,
      8'h5A, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00,
      8'h08, 8'h00, 8'h08, 8'h04, 8'h01, 8'h02, 8'h04,
      8'h68, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00,
      8'h08, 8'h00, 8'h08, 8'h04, 8'h02, 8'h02, 8'h05,
      8'h85, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF
   };

   // ----------------------------------------
   // read kinds in table column order
   // ----------------------------------------
   typedef enum logic [2:0] {
      SDL_K_SLOW,
      SDL_K_FAST,
      SDL_K_DOUT,
      SDL_K_QOUT,
      SDL_K_DIO,
      SDL_K_QIO
   } sdl_kind_t;

   typedef struct packed {
      sdl_kind_t kind;
      logic addr_done;
   } sdl_req_t;

   typedef struct packed {
      logic drive;
      logic unsup;
      logic [4:0] cycles;
   } sdl_stat_t;

endpackage : sdl_pkg
